// [common/sif_pkg.sv]
package sif_pkg;
  // ==========================================================================
  // synchroniser and reset values
  // ==========================================================================
  localparam int SYNC_STAGES = 2;            // flops before any logic reads a pin
  localparam logic RST_LOW   = 1'h0;         // reset value of control bits and the rx and fault flags
  localparam logic RST_HIGH  = 1'h1;         // reset value of idle-high pins
  localparam logic [1:0] SYNC_RST_HIGH = 2'h3;   // select pin idles high (inactive)
  // ==========================================================================
  // fault-guard states
  // ==========================================================================
  typedef enum logic [1:0] {
    SIF_IDLE,                                // no fault pending
    SIF_FAULT,                               // flag set, not yet read
    SIF_ARMED                                // flag read while set, awaiting write
  } sif_state_t;
endpackage

// [verilog/sif_sync.sv]
`timescale 1ns/1ps
// ==========================================================================
// two-flop synchroniser for one pin
// ==========================================================================
module sif_sync #(
  parameter logic RST_VAL = 1'h1             // value held while in reset
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_q;                              // first stage, read only by o_sync
  // both stages take a constant under reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // sif_sync

// [verilog/sif_top.sv]
`timescale 1ns/1ps
module sif_top (
  input  wire logic I_CLK_SYS,               // 20 MHz system clock
  input  wire logic I_RST,                   // async reset, active high
  input  wire logic I_SS_N,                  // slave-select pin, active low
  input  wire logic I_RX_FULL_SET,           // pulse: receive buffer filled
  input  wire logic I_RX_FULL_CLR,           // pulse: receive flag cleared
  input  wire logic I_TX_EMPTY_SET,          // pulse: transmit buffer emptied
  input  wire logic I_TX_EMPTY_CLR,          // pulse: transmit flag cleared
  input  wire logic I_CTL_WR,                // pulse: write to port_control_one
  input  wire logic I_WR_MASTER_SELECT,      // master bit value written
  input  wire logic I_WR_RX_MASK,            // rx_fault_irq_mask value written
  input  wire logic I_WR_TX_MASK,            // tx_empty_irq_mask value written
  input  wire logic I_WR_FAULT_EN,           // fault_detect_enable value written
  input  wire logic I_WR_SEL_OE,             // select_output_enable value written
  input  wire logic I_WR_BIDIR,              // single-wire bidirectional mode
  input  wire logic I_STATUS_RD,             // pulse: status register read
  input  wire logic I_SCK_OE_REQ,            // datapath wants to drive clock
  input  wire logic I_MOSI_OE_REQ,           // datapath wants to drive mosi
  input  wire logic I_MISO_OE_REQ,           // datapath wants to drive miso
  output logic      O_IRQ,                   // shared interrupt request, high
  output logic      O_RX_FULL_FLAG,          // rx_full_flag
  output logic      O_TX_EMPTY_FLAG,         // tx_empty_flag
  output logic      O_FAULT_FLAG,            // contention_fault_flag
  output logic      O_MASTER_SELECT,         // master_select control bit
  output logic      O_RX_MASK,               // rx_fault_irq_mask
  output logic      O_TX_MASK,               // tx_empty_irq_mask
  output logic      O_SCK_OE,                // serial_clock_pin driver enable
  output logic      O_MOSI_OE,               // mosi driver enable
  output logic      O_MISO_OE                // miso driver enable
);
  // ==========================================================================
  // declarations
  // ==========================================================================
  logic             ss_n_s;                  // synchronised select pin
  logic             fault_en_q;              // fault_detect_enable
  logic             sel_oe_q;                // select_output_enable
  logic             bidir_q;                 // bidirectional mode
  logic             fault_in;                // select pin acts as fault input
  logic             fault_hit;               // contention seen this cycle
  logic             fault_clr;               // read-then-write completes
  logic             irq_d;                   // next request value
  sif_pkg::sif_state_t st_q;                 // clear-sequence state
  sif_pkg::sif_state_t st_d;

  // ==========================================================================
  // pin input
  // ==========================================================================
  // pin is asynchronous to the system clock, so it crosses two flops first
  sif_sync #(
    .RST_VAL (sif_pkg::RST_HIGH)
  ) u_ss_sync (
    .i_clk   (I_CLK_SYS),
    .i_rst   (I_RST),
    .i_async (I_SS_N),
    .o_sync  (ss_n_s)
  );

  // ==========================================================================
  // fault detection
  // ==========================================================================
  // fault input only as master with detect on and select output off
  assign fault_in  = O_MASTER_SELECT & fault_en_q & ~sel_oe_q;
  assign fault_hit = fault_in & ~ss_n_s;

  // ==========================================================================
  // clear sequence: read while set, then a control write
  // ==========================================================================
  // a write without the earlier read leaves the flag alone
  always_comb begin
    st_d = st_q;
    case (st_q)
      sif_pkg::SIF_IDLE: begin
        if (fault_hit) st_d = sif_pkg::SIF_FAULT;
      end
      sif_pkg::SIF_FAULT: begin
        if (I_STATUS_RD) st_d = sif_pkg::SIF_ARMED;
      end
      sif_pkg::SIF_ARMED: begin
        // a fresh fault in the write cycle wins over the clear
        if (I_CTL_WR && !fault_hit) st_d = sif_pkg::SIF_IDLE;
        else if (I_CTL_WR) st_d = sif_pkg::SIF_FAULT;
      end
      default: st_d = sif_pkg::SIF_IDLE;
    endcase
  end
  assign fault_clr = (st_q == sif_pkg::SIF_ARMED) & I_CTL_WR & ~fault_hit;

  // state register
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) st_q <= sif_pkg::SIF_IDLE;
    else       st_q <= st_d;
  end

  // fault flag follows state; set has priority, held until the clear
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST)          O_FAULT_FLAG <= sif_pkg::RST_LOW;
    else if (fault_hit) O_FAULT_FLAG <= 1'h1;
    else if (fault_clr) O_FAULT_FLAG <= 1'b0;
  end

  // ==========================================================================
  // control bits
  // ==========================================================================
  // fault beats a software write of the master bit in the same cycle
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      O_MASTER_SELECT <= sif_pkg::RST_LOW;
      O_RX_MASK       <= sif_pkg::RST_LOW;
      O_TX_MASK       <= sif_pkg::RST_LOW;
      fault_en_q      <= sif_pkg::RST_LOW;
      sel_oe_q        <= sif_pkg::RST_LOW;
      bidir_q         <= sif_pkg::RST_LOW;
    end else begin
      if (fault_hit)     O_MASTER_SELECT <= 1'h0;
      else if (I_CTL_WR) O_MASTER_SELECT <= I_WR_MASTER_SELECT;
      if (I_CTL_WR) begin
        O_RX_MASK  <= I_WR_RX_MASK;
        O_TX_MASK  <= I_WR_TX_MASK;
        fault_en_q <= I_WR_FAULT_EN;
        sel_oe_q   <= I_WR_SEL_OE;
        bidir_q    <= I_WR_BIDIR;
      end
    end
  end

  // ==========================================================================
  // data event flags
  // ==========================================================================
  // flags set regardless of masks so software may poll; set wins over clear
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      O_RX_FULL_FLAG  <= sif_pkg::RST_LOW;
      O_TX_EMPTY_FLAG <= sif_pkg::RST_HIGH;
    end else begin
      if (I_RX_FULL_SET)       O_RX_FULL_FLAG  <= 1'h1;
      else if (I_RX_FULL_CLR)  O_RX_FULL_FLAG  <= 1'h0;
      if (I_TX_EMPTY_SET)      O_TX_EMPTY_FLAG <= 1'h1;
      else if (I_TX_EMPTY_CLR) O_TX_EMPTY_FLAG <= 1'h0;
    end
  end

  // ==========================================================================
  // shared interrupt request
  // ==========================================================================
  // registered from the flag values, so request lags a flag by one cycle
  assign irq_d = (O_RX_MASK & (O_RX_FULL_FLAG | O_FAULT_FLAG))
               | (O_TX_MASK & O_TX_EMPTY_FLAG);
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) O_IRQ <= sif_pkg::RST_LOW;
    else       O_IRQ <= irq_d;
  end

  // ==========================================================================
  // output driver enables
  // ==========================================================================
  // a fault drops sck and mosi, and miso outside bidir mode, in the same edge that sets the flag
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      O_SCK_OE  <= sif_pkg::RST_LOW;
      O_MOSI_OE <= sif_pkg::RST_LOW;
      O_MISO_OE <= sif_pkg::RST_LOW;
    end else begin
      O_SCK_OE  <= I_SCK_OE_REQ  & ~fault_hit & ~O_FAULT_FLAG;
      O_MOSI_OE <= I_MOSI_OE_REQ & ~fault_hit & ~O_FAULT_FLAG;
      O_MISO_OE <= I_MISO_OE_REQ
                 & (bidir_q | (~fault_hit & ~O_FAULT_FLAG));
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  sequence fault_seen_s;
    fault_hit;
  endsequence
  sequence fault_taken_s;
    ##1 (O_FAULT_FLAG && !O_MASTER_SELECT);
  endsequence

  fault_sets_flag_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    fault_seen_s |-> fault_taken_s)
    else $error("fault did not set flag and drop master");
  fault_input_cfg_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    (!O_MASTER_SELECT || !fault_en_q || sel_oe_q) |=> $stable(O_FAULT_FLAG) || !O_FAULT_FLAG)
    else $error("fault flag set without fault input");
  fault_holds_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    (O_FAULT_FLAG && !(st_q == sif_pkg::SIF_ARMED && I_CTL_WR)) |=> O_FAULT_FLAG)
    else $error("fault flag dropped without clear sequence");
  clear_needs_read_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    $fell(O_FAULT_FLAG) |-> $past(st_q == sif_pkg::SIF_ARMED) && $past(I_CTL_WR))
    else $error("fault flag cleared without read then write");
  rx_irq_gate_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    (O_RX_MASK && (O_RX_FULL_FLAG || O_FAULT_FLAG)) |=> O_IRQ)
    else $error("rx or fault event not requested");
  tx_irq_gate_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    (O_TX_MASK && O_TX_EMPTY_FLAG) |=> O_IRQ)
    else $error("tx empty not requested");
  irq_cause_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    O_IRQ |-> $past((O_RX_MASK && (O_RX_FULL_FLAG || O_FAULT_FLAG))
                    || (O_TX_MASK && O_TX_EMPTY_FLAG)))
    else $error("request without a masked flag");
  // both masks clear must silence the shared line, whatever the flags hold
  irq_masked_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    (!O_RX_MASK && !O_TX_MASK) |=> !O_IRQ)
    else $error("request raised with both masks clear");
  poll_flags_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    I_RX_FULL_SET |=> O_RX_FULL_FLAG)
    else $error("rx flag not set while masked");
  drivers_off_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    O_FAULT_FLAG |-> (!O_SCK_OE && !O_MOSI_OE) [*2])
    else $error("drivers enabled during fault");
  // data line is only kept in single-wire mode, where it is the sole link
  miso_release_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    (O_FAULT_FLAG && !bidir_q) |=> !O_MISO_OE)
    else $error("miso driven during fault outside single-wire mode");
endmodule // sif_top

// [verification/sif_other_master.sv]
`timescale 1ns/1ps
// ==========================================================================
// another port on the bus that may try to become master
// ==========================================================================
module sif_other_master (
  input  wire logic i_claim,                 // far device wants us as its slave
  output logic      o_ss_n                   // select line, pulled up when free
);
  // a claim pulls select low; a released line rises to its pull-up level,
  // so the block never sees a stale low after the far side lets go
  assign o_ss_n = i_claim ? 1'h0 : 1'h1;
endmodule // sif_other_master

// [verification/sif_top_bench.sv]
`timescale 1ns/1ps
// ==========================================================================
// self-checking bench for the interrupt and contention-guard block
// ==========================================================================
module sif_top_bench;
  logic clk, rst, ss_n, claim, rxs, rxc, txs, txc, wr, rd, req;  // driven inputs
  logic ms, rm, tm, fe, so, bd;              // control word fields
  logic irq, rxf, txf, flt, mst, rxk, txk;   // flag and control outputs
  logic sck, mosi, miso;                     // driver enables
  int   bad_count;                           // mismatches seen
  int   compares;                            // comparisons made
  // ==========================================================================
  // clock and design
  // ==========================================================================
  // 20 MHz system clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  sif_other_master sif_other_master_inst (.i_claim(claim), .o_ss_n(ss_n));
  sif_top sif_top_inst (.I_CLK_SYS(clk), .I_RST(rst), .I_SS_N(ss_n),
    .I_RX_FULL_SET(rxs), .I_RX_FULL_CLR(rxc), .I_TX_EMPTY_SET(txs),
    .I_TX_EMPTY_CLR(txc), .I_CTL_WR(wr), .I_WR_MASTER_SELECT(ms),
    .I_WR_RX_MASK(rm), .I_WR_TX_MASK(tm), .I_WR_FAULT_EN(fe), .I_WR_SEL_OE(so),
    .I_WR_BIDIR(bd), .I_STATUS_RD(rd), .I_SCK_OE_REQ(req), .I_MOSI_OE_REQ(req),
    .I_MISO_OE_REQ(req), .O_IRQ(irq), .O_RX_FULL_FLAG(rxf),
    .O_TX_EMPTY_FLAG(txf), .O_FAULT_FLAG(flt), .O_MASTER_SELECT(mst),
    .O_RX_MASK(rxk), .O_TX_MASK(txk), .O_SCK_OE(sck), .O_MOSI_OE(mosi),
    .O_MISO_OE(miso));
  // ==========================================================================
  // access tasks
  // ==========================================================================
  // one compare for every single-bit result
  task automatic chk(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask
  // control write: master, rx mask, tx mask, fault enable, select oe, bidir
  task automatic ctl(input logic [5:0] v);
    {ms, rm, tm, fe, so, bd} = v;
    wr = 1'h1;
    @(negedge clk);
    wr = 1'h0;
    repeat (3) @(negedge clk);               // flag edge plus irq edge settle
  endtask
  // one-cycle strobe, then let the registered outputs settle
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge clk);
    s = 1'h0;
    repeat (3) @(negedge clk);
  endtask
  // far master seizes select long enough to pass the synchroniser
  task automatic seize();
    claim = 1'h1;
    repeat (5) @(negedge clk);
  endtask
  task automatic end_sim();
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================================
  // tests
  // ==========================================================================
  logic [5:0] cfg [3] = '{6'h20, 6'h26, 6'h04};  // setups where select is no fault
  initial begin
    {rst, claim, rxs, rxc, txs, txc, wr, rd, ms, rm, tm, fe, so, bd} = '0;
    req = 1'h1;
    rst = 1'h1;
    repeat (6) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    chk("irq", 1'h0, irq);
    chk("tx_empty", 1'h1, txf);
    ctl(6'h08);
    chk("tx_mask", 1'h1, txk);
    chk("irq", 1'h1, irq);
    pulse(txc);
    chk("irq", 1'h0, irq);
    pulse(rxs);
    chk("rx_full", 1'h1, rxf);
    chk("irq", 1'h0, irq);
    ctl(6'h10);
    chk("irq", 1'h1, irq);
    pulse(rxc);
    chk("irq", 1'h0, irq);
    // tx flag must still set for polling while its mask is clear
    pulse(txs);
    chk("tx_empty", 1'h1, txf);
    chk("irq", 1'h0, irq);
    // select low must be ignored unless master, enabled and not an output
    foreach (cfg[i]) begin
      ctl(cfg[i]);
      seize();
      chk("fault", 1'h0, flt);
      claim = 1'h0;
      repeat (4) @(negedge clk);
    end
    ctl(6'h34);
    chk("master", 1'h1, mst);
    chk("rx_mask", 1'h1, rxk);
    chk("tx_mask", 1'h0, txk);
    chk("sck_oe", 1'h1, sck);
    seize();
    chk("fault", 1'h1, flt);
    chk("master", 1'h0, mst);
    chk("sck_oe", 1'h0, sck);
    chk("mosi_oe", 1'h0, mosi);
    chk("miso_oe", 1'h0, miso);
    chk("irq", 1'h1, irq);
    claim = 1'h0;
    repeat (4) @(negedge clk);
    ctl(6'h14);
    chk("fault", 1'h1, flt);
    chk("irq", 1'h1, irq);
    pulse(rd);
    ctl(6'h14);
    chk("fault", 1'h0, flt);
    chk("irq", 1'h0, irq);
    // single-wire mode keeps the data line driven through a fault
    ctl(6'h35);
    seize();
    chk("miso_oe", 1'h1, miso);
    chk("mosi_oe", 1'h0, mosi);
    claim = 1'h0;
    repeat (4) @(negedge clk);
    pulse(rd);
    ctl(6'h15);
    chk("fault", 1'h0, flt);
    chk("sck_oe", 1'h1, sck);
    // once the fault is gone, the drivers follow the datapath request again
    req = 1'h0;
    repeat (2) @(negedge clk);
    chk("sck_oe", 1'h0, sck);
    chk("miso_oe", 1'h0, miso);
    // a second reset in mid-run returns the control bits to idle
    rst = 1'h1;
    @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    chk("rx_mask", 1'h0, rxk);
    chk("tx_empty", 1'h1, txf);
    end_sim();
  end
  // watchdog: fires at 4000 cycles; the sequence needs about 120
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end
endmodule // sif_top_bench
